// [pkg/sdl_pkg.sv]
`default_nettype none
package sdl_pkg;
   // Core clock, in Hz
   localparam int unsigned CLK_HZ = 50_000_000;
   // The bit divisor is fixed for this crystal, in Hz (11.0592 MHz)
   localparam int unsigned NOMINAL_XTAL_HZ = 11_059_200;
   // Nominal line rate, in baud
   localparam int unsigned NOMINAL_BAUD = 9600;
   // Cycles per bit do not follow CLK_HZ, so the real rate scales with the clock
   localparam int unsigned BIT_CYCLES = NOMINAL_XTAL_HZ / NOMINAL_BAUD;
   localparam logic [10:0] BIT_CNT_MAX = 11'(BIT_CYCLES - 1);
   localparam logic [10:0] HALF_BIT_CNT = 11'(BIT_CYCLES / 2 - 1);
   localparam logic [3:0] UART_DATA_BITS = 4'h8;
   localparam logic [3:0] UART_STOP_POS = 4'h9;

   localparam logic [7:0] CH_COLON = 8'h3A;
   localparam logic [7:0] CH_SEMI = 8'h3B;
   localparam logic [7:0] CH_QUERY = 8'h21;
   localparam logic [7:0] RECORD_ACCEPT_BYTE = 8'h06;
   localparam logic [7:0] RECORD_REJECT_BYTE = 8'h15;

   localparam int unsigned PID_LEN = 8;
   localparam int unsigned REV_LEN = 3;
   localparam logic [3:0] ID_LEN = 4'hB;

   localparam logic [4:0] MAX_DATA = 5'h10;
   localparam logic [4:0] HDR_BYTES = 5'h4;
   localparam logic [7:0] TYPE_DATA = 8'h00;
   localparam logic [7:0] TYPE_EOF = 8'h01;
   localparam logic [1:0] RUN_LAST_NIB = 2'h3;

   localparam int unsigned FIFO_WIDTH = 8;
   localparam int unsigned FIFO_DEPTH = 8;

   localparam logic [15:0] ADDR_RST = 16'h0000;
   localparam logic [7:0] BYTE_RST = 8'h00;

   typedef enum logic [3:0] {
      ST_STRAP, ST_USER, ST_ERASE, ST_ID, ST_WAIT, ST_REC, ST_PROG, ST_REPLY, ST_RUN_ADDR, ST_RUN
   } sdl_state_e;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] data;
   } sdl_wr_s;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } sdl_byte_s;
endpackage
`default_nettype wire

// [src/sdl_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module sdl_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 8
) (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   // DEPTH must be a power of two so the pointers wrap by themselves
   localparam int unsigned AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0] cnt_q, cnt_d;
   logic push, pop;

   assign o_in_ready = (cnt_q != FULL_CNT);
   assign o_out_valid = (cnt_q != '0);
   assign o_out_data = mem_q[rd_q];

   always_comb begin
      push = i_in_valid && o_in_ready;
      pop = o_out_valid && i_out_ready;
      mem_d = mem_q;
      wr_d = wr_q;
      rd_d = rd_q;
      cnt_d = cnt_q;
      if (push) begin
         mem_d[wr_q] = i_in_data;
         wr_d = wr_q + 1'b1;
      end
      if (pop) begin
         rd_d = rd_q + 1'b1;
      end
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         mem_q <= mem_d;
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
   end
endmodule
`default_nettype wire

// [src/sdl_loader.sv]
`timescale 1ns/1ps
`default_nettype none
// How it works
// (R1) Loader only when strap low at reset
// (R2) Erase both memories, then send identity
// (R3) Identity: 8-byte product, 3-byte revision
// (R4) UART 8 data bits, no parity, 9600; code runs at about 43403 baud, the fixed divisor at CLK_HZ
// (R5) Divisor fixed for 11.0592 MHz crystal
// (R6) Byte 0x21 resends identity any time; code honours it only in ST_WAIT, ST_REC, ST_RUN_ADDR and ST_ID
// (R7) Host should interrogate before downloading
// (R8) Writes reach program memory only
// (R9) Host sends records unmodified
// (R10) Colon starts record, earlier bytes dropped
// (R11) Send 0x06 accepted, 0x15 rejected
// (R12) After reject, wait for next colon
// (R13) Host sends next record after accept
// (R14) Semicolon plus 4 hex chars runs code
// (R15) Host normally runs from FF00
// (R16) Without run command, stay in loader
// (R17) Record fields: count, address, type, data, checksum
// (R18) Type 00 programs, type 01 ends file
// (R19) Byte sum including checksum must be zero
// (R20) Hex pairs to bytes; bad char rejects
module sdl_loader
   import sdl_pkg::*;
#(
   // Arbitrary identity values
   parameter logic [8*PID_LEN-1:0] PRODUCT_ID = "SDLOADR ",
   parameter logic [8*REV_LEN-1:0] FW_REV = "v1a",
   // Only a bench shortens the bit; the device keeps the fixed divisor
   parameter int unsigned BIT_CLKS = BIT_CYCLES
) (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_loader_entry_strap_pin_n,
   input wire logic i_uart_rx,
   output logic o_uart_tx,
   output logic o_erase_req,
   input wire logic i_erase_done,
   output logic o_wr_valid,
   input wire logic i_wr_ready,
   input wire logic i_wr_ok,
   output sdl_wr_s o_wr,
   output logic o_run,
   output logic [15:0] o_run_addr,
   output logic o_loader_active,
   output logic o_user_mode
);
   localparam logic [8*(PID_LEN+REV_LEN)-1:0] ID_STRING = {PRODUCT_ID, FW_REV};
   localparam logic [10:0] BIT_MAX = 11'(BIT_CLKS - 1);
   localparam logic [10:0] HALF_MAX = 11'(BIT_CLKS / 2 - 1);

   sdl_state_e st_q, st_d;
   logic [3:0] id_idx_q, id_idx_d;
   logic [3:0] nib_hi_q, nib_hi_d;
   logic half_q, half_d;
   logic [4:0] byte_idx_q, byte_idx_d;
   logic [4:0] cnt_q, cnt_d;
   logic [15:0] addr_q, addr_d;
   logic [7:0] type_q, type_d;
   logic [7:0] sum_q, sum_d;
   logic [7:0] buf_q [16];
   logic [7:0] buf_d [16];
   logic [3:0] prog_idx_q, prog_idx_d;
   logic bad_q, bad_d;
   logic [7:0] reply_q, reply_d;
   logic run_pend_q, run_pend_d;
   logic [15:0] run_addr_q, run_addr_d;
   logic [1:0] run_nib_q, run_nib_d;
   logic run_q, run_d;
   sdl_wr_s wr_q, wr_d;
   logic push;
   logic [7:0] push_data;
   logic [4:0] hv;
   logic [7:0] b;
   logic fifo_in_ready, fifo_out_valid, fifo_pop;
   logic [7:0] fifo_out_data;

   // Receiver and transmitter state
   logic rx_busy_q, rx_busy_d;
   logic [10:0] rx_cnt_q, rx_cnt_d;
   logic [3:0] rx_bit_q, rx_bit_d;
   logic [7:0] rx_sh_q, rx_sh_d;
   sdl_byte_s rx_byte_q, rx_byte_d;
   logic tx_busy_q, tx_busy_d;
   logic [10:0] tx_cnt_q, tx_cnt_d;
   logic [3:0] tx_bit_q, tx_bit_d;
   logic [9:0] tx_sh_q, tx_sh_d;
   logic tx_line_q, tx_line_d;

   function automatic logic [4:0] hex_val(input logic [7:0] c);
      logic [4:0] r;
      r = 5'h00;
      if (c >= 8'h30 && c <= 8'h39) begin
         r = {1'b1, 4'(c - 8'h30)};
      end else if (c >= 8'h41 && c <= 8'h46) begin
         r = {1'b1, 4'(c - 8'h37)};
      end else if (c >= 8'h61 && c <= 8'h66) begin
         r = {1'b1, 4'(c - 8'h57)};
      end
      return r;
   endfunction

   // Replies go through the FIFO; a full FIFO stalls the identity sender
   sdl_fifo #(
      .WIDTH(FIFO_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) u_tx_fifo (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_in_valid(push),
      .o_in_ready(fifo_in_ready),
      .i_in_data(push_data),
      .o_out_valid(fifo_out_valid),
      .i_out_ready(fifo_pop),
      .o_out_data(fifo_out_data)
   );

   assign fifo_pop = !tx_busy_q;
   assign o_uart_tx = tx_line_q;
   assign o_erase_req = (st_q == ST_ERASE); // [R2]
   assign o_wr_valid = (st_q == ST_PROG); // [R8]
   assign o_wr = wr_q;
   assign o_run = run_q;
   assign o_run_addr = run_addr_q;
   assign o_user_mode = (st_q == ST_USER); // [R16]
   assign o_loader_active = (st_q != ST_STRAP) && (st_q != ST_USER) && (st_q != ST_RUN);

   // Serial line, bit timing from the fixed divisor
   always_comb begin
      rx_busy_d = rx_busy_q;
      rx_cnt_d = rx_cnt_q;
      rx_bit_d = rx_bit_q;
      rx_sh_d = rx_sh_q;
      rx_byte_d = '{valid: 1'b0, data: rx_byte_q.data};
      if (!rx_busy_q) begin
         if (!i_uart_rx) begin
            rx_busy_d = 1'b1;
            rx_cnt_d = HALF_MAX; // [R5]
            rx_bit_d = 4'h0;
         end
      end else if (rx_cnt_q != 11'h000) begin
         rx_cnt_d = rx_cnt_q - 11'h001;
      end else begin
         rx_cnt_d = BIT_MAX; // [R5]
         rx_bit_d = rx_bit_q + 4'h1;
         if (rx_bit_q == 4'h0) begin
            // A glitch shorter than half a bit is not a start bit
            rx_busy_d = !i_uart_rx;
         end else if (rx_bit_q <= UART_DATA_BITS) begin
            rx_sh_d = {i_uart_rx, rx_sh_q[7:1]}; // [R4]
         end else begin
            rx_busy_d = 1'b0;
            // Bytes with a broken stop bit are dropped
            rx_byte_d = '{valid: i_uart_rx, data: rx_sh_q};
         end
      end
      tx_busy_d = tx_busy_q;
      tx_cnt_d = tx_cnt_q;
      tx_bit_d = tx_bit_q;
      tx_sh_d = tx_sh_q;
      tx_line_d = tx_line_q;
      if (!tx_busy_q) begin
         if (fifo_out_valid) begin
            tx_busy_d = 1'b1;
            tx_sh_d = {1'b1, fifo_out_data, 1'b0}; // [R4]
            tx_cnt_d = BIT_MAX;
            tx_bit_d = 4'h0;
            tx_line_d = 1'b0;
         end
      end else if (tx_cnt_q != 11'h000) begin
         tx_cnt_d = tx_cnt_q - 11'h001;
      end else if (tx_bit_q == UART_STOP_POS) begin
         tx_busy_d = 1'b0;
      end else begin
         tx_cnt_d = BIT_MAX; // [R5]
         tx_bit_d = tx_bit_q + 4'h1;
         tx_sh_d = {1'b1, tx_sh_q[9:1]};
         tx_line_d = tx_sh_q[1];
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         rx_busy_q <= 1'b0;
         rx_cnt_q <= 11'h000;
         rx_bit_q <= 4'h0;
         rx_sh_q <= BYTE_RST;
         rx_byte_q <= '0;
         tx_busy_q <= 1'b0;
         tx_cnt_q <= 11'h000;
         tx_bit_q <= 4'h0;
         tx_sh_q <= 10'h3FF;
         tx_line_q <= 1'b1;
      end else begin
         rx_busy_q <= rx_busy_d;
         rx_cnt_q <= rx_cnt_d;
         rx_bit_q <= rx_bit_d;
         rx_sh_q <= rx_sh_d;
         rx_byte_q <= rx_byte_d;
         tx_busy_q <= tx_busy_d;
         tx_cnt_q <= tx_cnt_d;
         tx_bit_q <= tx_bit_d;
         tx_sh_q <= tx_sh_d;
         tx_line_q <= tx_line_d;
      end
   end

   // Loader sequence and record parser
   always_comb begin
      st_d = st_q;
      id_idx_d = id_idx_q;
      nib_hi_d = nib_hi_q;
      half_d = half_q;
      byte_idx_d = byte_idx_q;
      cnt_d = cnt_q;
      addr_d = addr_q;
      type_d = type_q;
      sum_d = sum_q;
      buf_d = buf_q;
      prog_idx_d = prog_idx_q;
      bad_d = bad_q;
      reply_d = reply_q;
      run_pend_d = run_pend_q;
      run_addr_d = run_addr_q;
      run_nib_d = run_nib_q;
      run_d = 1'b0;
      wr_d = wr_q;
      push = 1'b0;
      push_data = BYTE_RST;
      hv = hex_val(rx_byte_q.data);
      b = {nib_hi_q, hv[3:0]}; // [R20]
      unique case (st_q)
         ST_STRAP: begin
            st_d = i_loader_entry_strap_pin_n ? ST_USER : ST_ERASE; // [R1]
         end
         ST_USER: begin
         end
         ST_ERASE: begin
            if (i_erase_done) begin
               st_d = ST_ID; // [R2]
               id_idx_d = 4'h0;
            end
         end
         ST_ID: begin
            push = 1'b1;
            push_data = ID_STRING[8*int'(ID_LEN) - 1 - 8*int'(id_idx_q) -: 8]; // [R3]
            if (fifo_in_ready) begin
               id_idx_d = id_idx_q + 4'h1;
               if (id_idx_q == ID_LEN - 4'h1) begin
                  st_d = ST_WAIT;
               end
            end
         end
         ST_WAIT: begin
            if (rx_byte_q.valid && rx_byte_q.data == CH_COLON) begin
               st_d = ST_REC; // [R10]
               half_d = 1'b0;
               byte_idx_d = 5'h00;
               sum_d = BYTE_RST;
               bad_d = 1'b0;
            end else if (rx_byte_q.valid && rx_byte_q.data == CH_SEMI) begin
               st_d = ST_RUN_ADDR; // [R14]
               run_nib_d = 2'h0;
            end
         end
         ST_REC: begin
            if (rx_byte_q.valid) begin
               if (!hv[4]) begin
                  st_d = ST_REPLY; // [R20]
                  reply_d = RECORD_REJECT_BYTE;
               end else if (!half_q) begin
                  nib_hi_d = hv[3:0];
                  half_d = 1'b1;
               end else begin
                  half_d = 1'b0;
                  sum_d = sum_q + b; // [R19]
                  byte_idx_d = byte_idx_q + 5'h01;
                  if (byte_idx_q == 5'h00) begin
                     cnt_d = b[4:0]; // [R17]
                     if (b > 8'(MAX_DATA)) begin
                        st_d = ST_REPLY;
                        reply_d = RECORD_REJECT_BYTE;
                     end
                  end else if (byte_idx_q == 5'h01) begin
                     addr_d = {b, addr_q[7:0]};
                  end else if (byte_idx_q == 5'h02) begin
                     addr_d = {addr_q[15:8], b};
                  end else if (byte_idx_q == 5'h03) begin
                     type_d = b;
                  end else if (byte_idx_q < cnt_q + HDR_BYTES) begin
                     buf_d[4'(byte_idx_q - HDR_BYTES)] = b;
                  end else begin
                     // Checksum byte closes the record
                     st_d = ST_REPLY; // [R11]
                     reply_d = RECORD_REJECT_BYTE;
                     if (sum_q + b != BYTE_RST) begin
                        reply_d = RECORD_REJECT_BYTE; // [R19]
                     end else if (type_q == TYPE_EOF) begin
                        reply_d = RECORD_ACCEPT_BYTE; // [R18]
                     end else if (type_q == TYPE_DATA && cnt_q == 5'h00) begin
                        reply_d = RECORD_ACCEPT_BYTE;
                     end else if (type_q == TYPE_DATA) begin
                        st_d = ST_PROG; // [R18]
                        prog_idx_d = 4'h0;
                        wr_d = '{addr: addr_q, data: buf_q[0]};
                     end
                  end
               end
            end
         end
         ST_PROG: begin
            if (i_wr_ready) begin
               bad_d = bad_q || !i_wr_ok; // [R11]
               if (prog_idx_q == 4'(cnt_q - 5'h01)) begin
                  st_d = ST_REPLY; // [R11]
                  reply_d = (bad_q || !i_wr_ok) ? RECORD_REJECT_BYTE : RECORD_ACCEPT_BYTE;
               end else begin
                  prog_idx_d = prog_idx_q + 4'h1;
                  wr_d = '{addr: wr_q.addr + 16'h0001, data: buf_q[prog_idx_q + 4'h1]};
               end
            end
         end
         ST_REPLY: begin
            push = 1'b1;
            push_data = reply_q; // [R11]
            if (fifo_in_ready) begin
               st_d = run_pend_q ? ST_RUN : ST_WAIT; // [R12]
               run_d = run_pend_q; // [R14]
               run_pend_d = 1'b0;
            end
         end
         ST_RUN_ADDR: begin
            if (rx_byte_q.valid) begin
               if (!hv[4]) begin
                  st_d = ST_REPLY;
                  reply_d = RECORD_REJECT_BYTE;
               end else begin
                  run_addr_d = {run_addr_q[11:0], hv[3:0]}; // [R14]
                  run_nib_d = run_nib_q + 2'h1;
                  if (run_nib_q == RUN_LAST_NIB) begin
                     st_d = ST_REPLY;
                     reply_d = RECORD_ACCEPT_BYTE;
                     run_pend_d = 1'b1;
                  end
               end
            end
         end
         ST_RUN: begin
         end
      endcase
      // Interrogation wins over any parse in progress
      if (rx_byte_q.valid && rx_byte_q.data == CH_QUERY && (st_q == ST_WAIT || st_q == ST_REC
          || st_q == ST_RUN_ADDR || st_q == ST_ID)) begin
         st_d = ST_ID; // [R6]
         id_idx_d = 4'h0;
         half_d = 1'b0;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         st_q <= ST_STRAP;
         id_idx_q <= 4'h0;
         nib_hi_q <= 4'h0;
         half_q <= 1'b0;
         byte_idx_q <= 5'h00;
         cnt_q <= 5'h00;
         addr_q <= ADDR_RST;
         type_q <= BYTE_RST;
         sum_q <= BYTE_RST;
         for (int i = 0; i < 16; i++) begin
            buf_q[i] <= BYTE_RST;
         end
         prog_idx_q <= 4'h0;
         bad_q <= 1'b0;
         reply_q <= BYTE_RST;
         run_pend_q <= 1'b0;
         run_addr_q <= ADDR_RST;
         run_nib_q <= 2'h0;
         run_q <= 1'b0;
         wr_q <= '0;
      end else begin
         st_q <= st_d;
         id_idx_q <= id_idx_d;
         nib_hi_q <= nib_hi_d;
         half_q <= half_d;
         byte_idx_q <= byte_idx_d;
         cnt_q <= cnt_d;
         addr_q <= addr_d;
         type_q <= type_d;
         sum_q <= sum_d;
         buf_q <= buf_d;
         prog_idx_q <= prog_idx_d;
         bad_q <= bad_d;
         reply_q <= reply_d;
         run_pend_q <= run_pend_d;
         run_addr_q <= run_addr_d;
         run_nib_q <= run_nib_d;
         run_q <= run_d;
         wr_q <= wr_d;
      end
   end
endmodule
`default_nettype wire

// [tb/sdl_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module sdl_host_model
   import sdl_pkg::*;
#(
   parameter int unsigned BIT_CLKS = BIT_CYCLES
) (
   input wire logic i_core_clk,
   input wire logic i_uart_tx,
   output logic o_uart_rx,
   output logic o_rx_valid,
   output logic [7:0] o_rx_byte
);
   initial begin
      o_uart_rx = 1'b1;
      o_rx_valid = 1'b0;
      o_rx_byte = 8'h00;
   end
   // Bit length must match the loader's divisor, not the real clock
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge i_core_clk);
         #1;
         o_uart_rx = f[i];
         repeat (BIT_CLKS - 1) @(posedge i_core_clk);
      end
   endtask
   // Sampling on the falling clock edge keeps clear of the line's updates
   initial begin
      forever begin
         @(negedge i_uart_tx);
         repeat (BIT_CLKS / 2) @(negedge i_core_clk);
         if (i_uart_tx == 1'b0) begin
            for (int i = 0; i < 8; i++) begin
               repeat (BIT_CLKS) @(negedge i_core_clk);
               o_rx_byte[i] = i_uart_tx;
            end
            repeat (BIT_CLKS) @(negedge i_core_clk);
            o_rx_valid = i_uart_tx;
            @(negedge i_core_clk);
            o_rx_valid = 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// [tb/sdl_loader_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module sdl_loader_checker
   import sdl_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_loader_entry_strap_pin_n,
   input wire logic i_uart_rx,
   input wire logic o_uart_tx,
   input wire logic o_erase_req,
   input wire logic i_erase_done,
   input wire logic o_wr_valid,
   input wire logic i_wr_ready,
   input wire logic i_wr_ok,
   input wire sdl_wr_s o_wr,
   input wire logic o_run,
   input wire logic [15:0] o_run_addr,
   input wire logic o_loader_active,
   input wire logic o_user_mode
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   sequence s_release;
      $past(i_rst) && !i_rst;
   endsequence
   sequence s_erase_end;
      o_erase_req && i_erase_done;
   endsequence
   strap_low_a: assert property (s_release ##0 !i_loader_entry_strap_pin_n |-> ##[1:3] o_erase_req && !o_user_mode)
      else $error("loader not entered with strap low");
   strap_high_a: assert property (s_release ##0 i_loader_entry_strap_pin_n |-> ##[1:3] o_user_mode && !o_erase_req)
      else $error("user mode not entered with strap high");
   user_quiet_a: assert property (o_user_mode |-> !o_loader_active && !o_erase_req && !o_wr_valid && o_uart_tx)
      else $error("loader activity in user mode");
   erase_first_a: assert property (o_erase_req |-> o_uart_tx && !o_wr_valid && o_loader_active)
      else $error("traffic during erase");
   erase_hold_a: assert property (o_erase_req && !i_erase_done |=> o_erase_req)
      else $error("erase request dropped early");
   id_start_a: assert property (s_erase_end |-> ##[1:2] !o_erase_req ##[0:4] !o_uart_tx)
      else $error("identity not started after erase");
   wr_hold_a: assert property (o_wr_valid && !i_wr_ready |=> o_wr_valid && $stable(o_wr))
      else $error("write changed before taken");
   run_once_a: assert property (o_run |=> !o_run && !o_loader_active && $stable(o_run_addr))
      else $error("run pulse or run address wrong");
   run_seen_c: cover property (o_run);
endmodule
bind sdl_loader sdl_loader_checker u_chk (
   .i_core_clk(i_core_clk), .i_rst(i_rst),
   .i_loader_entry_strap_pin_n(i_loader_entry_strap_pin_n),
   .i_uart_rx(i_uart_rx), .o_uart_tx(o_uart_tx), .o_erase_req(o_erase_req),
   .i_erase_done(i_erase_done), .o_wr_valid(o_wr_valid), .i_wr_ready(i_wr_ready),
   .i_wr_ok(i_wr_ok), .o_wr(o_wr), .o_run(o_run), .o_run_addr(o_run_addr),
   .o_loader_active(o_loader_active), .o_user_mode(o_user_mode)
);
`default_nettype wire

// [tb/sdl_loader_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module sdl_loader_tb;
   import sdl_pkg::*;
   // Arbitrary identity values
   localparam logic [63:0] PID = "BENCHID1";
   localparam logic [23:0] REV = "t9z";
   // Short bits keep the run small; about 25k cycles are needed
   localparam int unsigned TB_BIT = 16;
   localparam int LIMIT = 40_000;
   logic i_core_clk;
   logic i_rst;
   logic strap_n;
   logic i_erase_done;
   logic i_wr_ready;
   logic i_wr_ok;
   wire logic uart_rx;
   wire logic uart_tx;
   logic o_erase_req;
   logic o_wr_valid;
   logic o_run;
   logic o_loader_active;
   logic o_user_mode;
   logic [15:0] o_run_addr;
   sdl_wr_s o_wr;
   logic rx_valid;
   logic [7:0] rx_byte;
   logic [7:0] tx_q[$];
   logic [23:0] wr_q[$];
   logic [15:0] a;
   logic [7:0] d;
   logic [7:0] e;
   logic [7:0] c;
   logic wr_bad = 1'b0;
   string bad[3] = '{":00000001FE", ":0G", ":11"};
   int fails = 0;
   int total_checks = 0;
   int cycles = 0;
   int runs = 0;

   initial begin
      i_core_clk = 1'b0;
      forever #10 i_core_clk = ~i_core_clk;
   end

   sdl_loader #(.PRODUCT_ID(PID), .FW_REV(REV), .BIT_CLKS(TB_BIT)) uut (
      .i_core_clk(i_core_clk), .i_rst(i_rst), .i_loader_entry_strap_pin_n(strap_n),
      .i_uart_rx(uart_rx), .o_uart_tx(uart_tx), .o_erase_req(o_erase_req),
      .i_erase_done(i_erase_done), .o_wr_valid(o_wr_valid), .i_wr_ready(i_wr_ready),
      .i_wr_ok(i_wr_ok), .o_wr(o_wr), .o_run(o_run), .o_run_addr(o_run_addr),
      .o_loader_active(o_loader_active), .o_user_mode(o_user_mode)
   );
   sdl_host_model #(.BIT_CLKS(TB_BIT)) host (
      .i_core_clk(i_core_clk), .i_uart_tx(uart_tx), .o_uart_rx(uart_rx),
      .o_rx_valid(rx_valid), .o_rx_byte(rx_byte)
   );

   task check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task complete_run();
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task send_text(input string s);
      for (int i = 0; i < s.len(); i++) begin
         host.send_byte(s[i]);
      end
   endtask

   task expect_id();
      for (int i = 0; i < 8; i++) tx_q.push_back(PID[63-8*i -: 8]);
      for (int i = 0; i < 3; i++) tx_q.push_back(REV[23-8*i -: 8]);
   endtask

   // Host waits for each reply before the next record
   task drain();
      int n;
      n = 0;
      while ((tx_q.size() + wr_q.size()) != 0 && n < 20_000) begin
         @(posedge i_core_clk);
         n++;
      end
      repeat (1200) @(posedge i_core_clk);
      #1;
      check("pending", 24'(tx_q.size() + wr_q.size()), 24'h00_0000);
   endtask

   // Memory side: random erase and write latency
   initial begin
      i_erase_done = 1'b0;
      i_wr_ready = 1'b0;
      i_wr_ok = 1'b1;
      forever begin
         @(posedge i_core_clk);
         #1;
         i_wr_ready = ($urandom % 3) != 0;
         i_wr_ok = !wr_bad;
         i_erase_done = o_erase_req && (($urandom % 8) == 0);
      end
   end

   always @(posedge i_core_clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         fails++;
         complete_run();
      end
   end

   always @(posedge i_core_clk) begin
      if (!i_rst && o_wr_valid && i_wr_ready) begin
         if (wr_q.size() == 0) check("wr_extra", o_wr, 24'h00_0000);
         else check("wr", o_wr, wr_q.pop_front());
      end
      if (rx_valid) begin
         if (tx_q.size() == 0) check("tx_extra", {16'h0000, rx_byte}, 24'h00_0000);
         else check("tx", {16'h0000, rx_byte}, {16'h0000, tx_q.pop_front()});
      end
      if (o_run) begin
         runs++;
         check("run_addr", {8'h00, o_run_addr}, 24'h00_FF00);
      end
   end

   initial begin
      void'($urandom(32'ha7af));
      i_rst = 1'b1;
      strap_n = 1'b0;
      repeat (16) @(posedge i_core_clk);
      #1;
      i_rst = 1'b0;
      expect_id();
      drain();
      a = 16'($urandom);
      d = 8'($urandom);
      e = 8'($urandom);
      c = 8'h00 - (8'h02 + a[15:8] + a[7:0] + d + e);
      // Second pass fails the write verify, so the same record is rejected
      for (int k = 0; k < 2; k++) begin
         wr_bad = k[0];
         wr_q.push_back({a, d});
         wr_q.push_back({16'(a + 16'h0001), e});
         tx_q.push_back(k[0] ? RECORD_REJECT_BYTE : RECORD_ACCEPT_BYTE);
         send_text($sformatf("zq:02%04X00%02x%02X%02X", a, d, e, c));
         drain();
      end
      wr_bad = 1'b0;
      for (int i = 0; i < 3; i++) begin
         tx_q.push_back(RECORD_REJECT_BYTE);
         send_text(bad[i]);
         drain();
      end
      tx_q.push_back(RECORD_ACCEPT_BYTE);
      send_text(":00000001FF");
      drain();
      expect_id();
      send_text("!");
      drain();
      tx_q.push_back(RECORD_ACCEPT_BYTE);
      send_text(";FF00");
      drain();
      check("run_count", 24'(runs), 24'h00_0001);
      i_rst = 1'b1;
      strap_n = 1'b1;
      repeat (16) @(posedge i_core_clk);
      #1;
      i_rst = 1'b0;
      repeat (4) @(posedge i_core_clk);
      #1;
      check("user_mode", {23'h00_0000, o_user_mode}, 24'h00_0001);
      check("erase_idle", {23'h00_0000, o_erase_req}, 24'h00_0000);
      complete_run();
   end
endmodule
`default_nettype wire
